// [hw/brl_pkg.sv]
// Purpose: Shared constants and types for the burner rate limiter
// Assumes: 50 MHz sys_clk, temperatures in whole degrees F
// Notes:   Register map is word aligned on AHB-Lite
package brl_pkg;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned SEC_S         = 1;
    localparam int unsigned SEC_CYCLES    = CLK_HZ * SEC_S;
    localparam int unsigned SLOW_STEP_S   = 10;
    localparam int unsigned STEPS_PER_MIN = 60 / SLOW_STEP_S;
    localparam logic [15:0] HILIM_BAND_F  = 16'h0005;
    localparam logic [15:0] ACOND_BAND_F  = 16'h0004;

    localparam logic [7:0] OFF_CTRL       = 8'h00;
    localparam logic [7:0] OFF_SH_FTIME   = 8'h04;
    localparam logic [7:0] OFF_SH_FRATE   = 8'h08;
    localparam logic [7:0] OFF_HW_FTIME   = 8'h0C;
    localparam logic [7:0] OFF_HW_FRATE   = 8'h10;
    localparam logic [7:0] OFF_SLOW_OFF   = 8'h14;
    localparam logic [7:0] OFF_SLOW_RAMP  = 8'h18;
    localparam logic [7:0] OFF_HILIM_SP   = 8'h1C;
    localparam logic [7:0] OFF_SH_AC_SP   = 8'h20;
    localparam logic [7:0] OFF_HW_AC_SP   = 8'h24;
    localparam logic [7:0] OFF_SH_MAX     = 8'h28;
    localparam logic [7:0] OFF_HW_MAX     = 8'h2C;
    localparam logic [7:0] OFF_STATUS     = 8'h30;
    localparam logic [7:0] OFF_RATE       = 8'h34;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h38;
    localparam logic [7:0] OFF_IRQ_CLR    = 8'h3C;
    localparam logic [7:0] OFF_IRQ_EN     = 8'h40;

    // Control register fields
    localparam int CTL_SH_SLOW_EN  = 0;
    localparam int CTL_HW_SLOW_EN  = 1;
    localparam int CTL_HILIM_EN    = 2;
    localparam int CTL_HILIM_LOCK  = 3;
    localparam int CTL_SH_AC_EN    = 4;
    localparam int CTL_HW_AC_EN    = 5;
    localparam int CTL_AC_PUMP_OFF = 6;
    localparam int CTL_PRIO_LSB    = 8;
    localparam int CTL_W           = 13;
    // Priority bits: anticondensation beats this limit when set
    localparam int PRIO_STACK  = 0;
    localparam int PRIO_DELTAT = 1;
    localparam int PRIO_SLOW   = 2;
    localparam int PRIO_FORCED = 3;
    localparam int PRIO_OUTLET = 4;

    // Interrupt status bits
    localparam int EV_SH_ALERT = 0;
    localparam int EV_HW_ALERT = 1;
    localparam int EV_HILIM    = 2;
    localparam int EV_ACOND    = 3;
    localparam int EV_W        = 4;

    localparam logic [CTL_W-1:0] CTRL_RST = 13'h0000;
    localparam logic [15:0]      MAX_RST  = 16'hFFFF;
    localparam logic [15:0]      WORD_RST = 16'h0000;

    typedef enum logic [1:0] {SRC_NONE, SRC_SPACE_HEATING, SRC_HOT_WATER,
                              SRC_LEAD_LAG} brl_src_t;
    typedef enum logic [1:0] {PH_IDLE, PH_FORCED, PH_SLOW, PH_RUN} brl_phase_t;
endpackage : brl_pkg

// [hw/brl_hyst_if.sv]
// Purpose: Carries one hysteresis comparison between limiter modules
// Assumes: Same clock domain on both ends
// Notes:   user drives the inputs, core returns the latched state
interface brl_hyst_if;
    logic        en;
    logic [15:0] temp;
    logic [15:0] level;
    logic        active;
    modport core (input en, input temp, input level, output active);
    modport user (output en, output temp, output level, input active);
endinterface : brl_hyst_if

// [hw/brl_hyst.sv]
// Purpose: Latched threshold with a fixed hysteresis band
// Assumes: Unsigned whole-degree temperatures
// Notes:   ABOVE=1 trips at or over level, releases below level-BAND
module brl_hyst #(
    parameter bit          ABOVE = 1'b1,
    parameter logic [15:0] BAND  = 16'h0005
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    brl_hyst_if.core        h
);
    typedef struct packed {
        logic active;
    } brl_hyst_st_t;

    brl_hyst_st_t s_reg;
    brl_hyst_st_t s_next;
    logic [16:0]  lo_thr;
    logic [16:0]  hi_thr;

    assign lo_thr   = {1'b0, h.level} - {1'b0, BAND};
    assign hi_thr   = {1'b0, h.level} + {1'b0, BAND};
    assign h.active = s_reg.active;

    always_comb begin
        s_next = s_reg;
        if (!h.en) begin
            s_next.active = 1'b0;
        end else if (ABOVE) begin
            if (h.temp >= h.level) begin
                s_next.active = 1'b1;
            end else if (!lo_thr[16] && ({1'b0, h.temp} < lo_thr)) begin
                s_next.active = 1'b0;
            end
        end else begin
            if (h.temp < h.level) begin
                s_next.active = 1'b1;
            end else if ({1'b0, h.temp} >= hi_thr) begin
                s_next.active = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : brl_hyst

// [hw/brl_top.sv]
// Purpose: Forced rate, slow start, hot-water high limit, anticondensation
// Assumes: Inputs come from logic on sys_clk; temperatures in degrees F
// Notes:   Registers on AHB-Lite; reads take one wait state
module brl_top #(
    parameter int unsigned SEC_CYCLES = brl_pkg::SEC_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        firing,
    input  wire logic        lightoff_done,
    input  wire logic [1:0]  demand_src,
    input  wire logic [15:0] outlet_temp,
    input  wire logic [15:0] hot_water_temp,
    input  wire logic [15:0] active_setpoint,
    input  wire logic [15:0] demand_rate,
    input  wire logic [15:0] stack_ceiling,
    input  wire logic [15:0] delta_t_ceiling,
    input  wire logic [15:0] outlet_ceiling,
    output logic [15:0]      rate_out,
    output logic             hot_water_pump_off,
    output logic             space_heating_pump_off,
    output logic             lockout_req,
    output logic             recycle_hold,
    output logic             irq
);
    typedef struct packed {
        logic [brl_pkg::CTL_W-1:0] ctrl;
        logic [15:0]               sh_ftime;
        logic [15:0]               sh_frate;
        logic [15:0]               hw_ftime;
        logic [15:0]               hw_frate;
        logic [15:0]               slow_off;
        logic [15:0]               slow_ramp;
        logic [15:0]               hilim_sp;
        logic [15:0]               sh_ac_sp;
        logic [15:0]               hw_ac_sp;
        logic [15:0]               sh_max;
        logic [15:0]               hw_max;
        logic [brl_pkg::EV_W-1:0]  irq_st;
        logic [brl_pkg::EV_W-1:0]  irq_en;
        brl_pkg::brl_phase_t       phase;
        logic                      src_hw;
        logic [31:0]               cyc_cnt;
        logic [15:0]               sec_left;
        logic [3:0]                step_cnt;
        logic [15:0]               ceil;
        logic                      hilim_d;
        logic                      acond_d;
        logic                      dp_wr;
        logic                      dp_rd;
        logic [7:0]                dp_addr;
        logic                      ready;
        logic [31:0]               rdata;
        logic                      resp;
        logic [15:0]               rate;
        logic                      hw_pump_off;
        logic                      sh_pump_off;
        logic                      lockout;
        logic                      hold;
        logic                      irq;
    } brl_st_t;

    brl_st_t    s_reg;
    brl_st_t    s_next;
    brl_hyst_if hl_if ();
    brl_hyst_if ac_if ();

    logic        src_is_hw;
    logic        src_is_sh;
    logic        acond_en;
    logic        acond_act;
    logic [15:0] src_max;
    logic [15:0] ramp_step;
    logic [16:0] ceil_sum;
    logic        slow_eff;
    logic        tick;
    logic [4:0]  prio;
    logic [15:0] sel_ftime;
    logic [15:0] sel_frate;
    logic [15:0] lat_max;
    logic        sel_slow_en;

    brl_hyst #(.ABOVE(1'b1), .BAND(brl_pkg::HILIM_BAND_F)) u_hilim (
        .sys_clk (sys_clk),
        .rst     (rst),
        .h       (hl_if.core)
    );

    brl_hyst #(.ABOVE(1'b0), .BAND(brl_pkg::ACOND_BAND_F)) u_acond (
        .sys_clk (sys_clk),
        .rst     (rst),
        .h       (ac_if.core)
    );

    assign src_is_hw = (demand_src == brl_pkg::SRC_HOT_WATER);
    assign src_is_sh = (demand_src == brl_pkg::SRC_SPACE_HEATING)
                    || (demand_src == brl_pkg::SRC_LEAD_LAG);
    assign prio      = s_reg.ctrl[brl_pkg::CTL_PRIO_LSB +: 5];

    assign hl_if.en    = s_reg.ctrl[brl_pkg::CTL_HILIM_EN];
    assign hl_if.temp  = hot_water_temp;
    assign hl_if.level = s_reg.hilim_sp;

    // Hot-water setpoint only while hot water controls; others use heating
    assign acond_en = firing && ((src_is_sh && s_reg.ctrl[brl_pkg::CTL_SH_AC_EN])
                   || (src_is_hw && s_reg.ctrl[brl_pkg::CTL_HW_AC_EN]));
    assign ac_if.en    = acond_en;
    assign ac_if.temp  = outlet_temp;
    assign ac_if.level = src_is_hw ? s_reg.hw_ac_sp : s_reg.sh_ac_sp;
    // Gate with the enable so a source change drops the request at once
    assign acond_act   = acond_en && ac_if.active;

    assign src_max   = src_is_hw ? s_reg.hw_max : s_reg.sh_max;
    assign lat_max   = s_reg.src_hw ? s_reg.hw_max : s_reg.sh_max;
    assign ramp_step = 16'(s_reg.slow_ramp / 16'(brl_pkg::STEPS_PER_MIN));
    assign ceil_sum  = {1'b0, s_reg.ceil} + {1'b0, ramp_step};
    // Compare as sum to avoid wrap when offset exceeds setpoint
    assign slow_eff  = ({1'b0, outlet_temp} + {1'b0, s_reg.slow_off})
                     < {1'b0, active_setpoint};
    assign tick      = (s_reg.cyc_cnt == SEC_CYCLES - 1);

    // Parameters of the source captured at lightoff
    assign sel_ftime   = src_is_hw ? s_reg.hw_ftime : s_reg.sh_ftime;
    assign sel_frate   = s_reg.src_hw ? s_reg.hw_frate : s_reg.sh_frate;
    assign sel_slow_en = s_reg.src_hw ? s_reg.ctrl[brl_pkg::CTL_HW_SLOW_EN]
                                      : s_reg.ctrl[brl_pkg::CTL_SH_SLOW_EN];

    function automatic logic [31:0] rd_mux(input brl_st_t st, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == brl_pkg::OFF_CTRL) begin
            d = {19'h0, st.ctrl};
        end else if (a == brl_pkg::OFF_SH_FTIME) begin
            d = {16'h0, st.sh_ftime};
        end else if (a == brl_pkg::OFF_SH_FRATE) begin
            d = {16'h0, st.sh_frate};
        end else if (a == brl_pkg::OFF_HW_FTIME) begin
            d = {16'h0, st.hw_ftime};
        end else if (a == brl_pkg::OFF_HW_FRATE) begin
            d = {16'h0, st.hw_frate};
        end else if (a == brl_pkg::OFF_SLOW_OFF) begin
            d = {16'h0, st.slow_off};
        end else if (a == brl_pkg::OFF_SLOW_RAMP) begin
            d = {16'h0, st.slow_ramp};
        end else if (a == brl_pkg::OFF_HILIM_SP) begin
            d = {16'h0, st.hilim_sp};
        end else if (a == brl_pkg::OFF_SH_AC_SP) begin
            d = {16'h0, st.sh_ac_sp};
        end else if (a == brl_pkg::OFF_HW_AC_SP) begin
            d = {16'h0, st.hw_ac_sp};
        end else if (a == brl_pkg::OFF_SH_MAX) begin
            d = {16'h0, st.sh_max};
        end else if (a == brl_pkg::OFF_HW_MAX) begin
            d = {16'h0, st.hw_max};
        end else if (a == brl_pkg::OFF_STATUS) begin
            d = {24'h0, st.hold, st.lockout, st.acond_d, st.hilim_d,
                 1'b0, st.src_hw, st.phase};
        end else if (a == brl_pkg::OFF_RATE) begin
            d = {st.ceil, st.rate};
        end else if (a == brl_pkg::OFF_IRQ_STAT) begin
            d = {28'h0, st.irq_st};
        end else if (a == brl_pkg::OFF_IRQ_EN) begin
            d = {28'h0, st.irq_en};
        end
        return d;
    endfunction : rd_mux

    always_comb begin
        logic [brl_pkg::EV_W-1:0] ev;
        logic [brl_pkg::EV_W-1:0] clr;
        logic [15:0]              r;
        logic                     to_slow;
        ev      = '0;
        clr     = '0;
        r       = 16'h0000;
        to_slow = 1'b0;
        s_next  = s_reg;

        // Bus: writes commit in the data phase, reads insert one wait
        s_next.dp_wr = 1'b0;
        s_next.resp  = 1'b0;
        if (s_reg.dp_rd) begin
            s_next.rdata = rd_mux(s_reg, s_reg.dp_addr);
            s_next.ready = 1'b1;
            s_next.dp_rd = 1'b0;
        end else if (hsel && htrans[1] && hready) begin
            s_next.dp_addr = haddr[7:0];
            s_next.dp_wr   = hwrite;
            s_next.dp_rd   = !hwrite;
            s_next.ready   = hwrite;
        end
        if (s_reg.dp_wr) begin
            if (s_reg.dp_addr == brl_pkg::OFF_CTRL) begin
                s_next.ctrl = hwdata[brl_pkg::CTL_W-1:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SH_FTIME) begin
                s_next.sh_ftime = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SH_FRATE) begin
                s_next.sh_frate = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_HW_FTIME) begin
                s_next.hw_ftime = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_HW_FRATE) begin
                s_next.hw_frate = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SLOW_OFF) begin
                s_next.slow_off = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SLOW_RAMP) begin
                s_next.slow_ramp = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_HILIM_SP) begin
                s_next.hilim_sp = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SH_AC_SP) begin
                s_next.sh_ac_sp = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_HW_AC_SP) begin
                s_next.hw_ac_sp = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_SH_MAX) begin
                s_next.sh_max = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_HW_MAX) begin
                s_next.hw_max = hwdata[15:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_IRQ_CLR) begin
                clr = hwdata[brl_pkg::EV_W-1:0];
            end else if (s_reg.dp_addr == brl_pkg::OFF_IRQ_EN) begin
                s_next.irq_en = hwdata[brl_pkg::EV_W-1:0];
            end
        end

        // One-second time base, counting in every phase except PH_IDLE
        if (s_reg.phase == brl_pkg::PH_IDLE || tick) begin
            s_next.cyc_cnt = 32'h0000_0000;
        end else begin
            s_next.cyc_cnt = s_reg.cyc_cnt + 32'h0000_0001;
        end

        case (s_reg.phase)
            brl_pkg::PH_IDLE: begin
                if (firing && lightoff_done) begin
                    s_next.src_hw   = src_is_hw;
                    s_next.sec_left = sel_ftime;
                    s_next.phase    = brl_pkg::PH_FORCED;
                end
            end
            brl_pkg::PH_FORCED: begin
                if (s_reg.sec_left == 16'h0000) begin
                    to_slow = 1'b1;
                end else if (tick) begin
                    s_next.sec_left = s_reg.sec_left - 16'h0001;
                end
            end
            brl_pkg::PH_SLOW: begin
                if (tick) begin
                    if (s_reg.step_cnt == 4'(brl_pkg::SLOW_STEP_S - 1)) begin
                        s_next.step_cnt = 4'h0;
                        s_next.ceil     = ceil_sum[16] ? 16'hFFFF
                                        : ceil_sum[15:0];
                    end else begin
                        s_next.step_cnt = s_reg.step_cnt + 4'h1;
                    end
                end
                if (s_reg.ceil >= lat_max) begin
                    s_next.phase = brl_pkg::PH_RUN;
                end
            end
            default: begin
            end
        endcase
        if (to_slow) begin
            s_next.step_cnt = 4'h0;
            s_next.ceil     = sel_frate;
            if (sel_slow_en && sel_frate != 16'h0000 && sel_frate <= lat_max) begin
                s_next.phase = brl_pkg::PH_SLOW;
            end else begin
                s_next.phase = brl_pkg::PH_RUN;
                if (sel_slow_en) begin
                    ev[s_reg.src_hw ? brl_pkg::EV_HW_ALERT
                                    : brl_pkg::EV_SH_ALERT] = 1'b1;
                end
            end
        end
        if (!firing) begin
            s_next.phase = brl_pkg::PH_IDLE;
        end

        // Rate selection; a set priority bit lets anticondensation win
        if (s_reg.phase == brl_pkg::PH_FORCED
            && !(acond_act && prio[brl_pkg::PRIO_FORCED])) begin
            r = sel_frate;
        end else begin
            r = acond_act ? src_max : demand_rate;
            if (!(acond_act && prio[brl_pkg::PRIO_STACK]) && stack_ceiling < r) begin
                r = stack_ceiling;
            end
            if (!(acond_act && prio[brl_pkg::PRIO_DELTAT]) && delta_t_ceiling < r) begin
                r = delta_t_ceiling;
            end
            if (!(acond_act && prio[brl_pkg::PRIO_OUTLET]) && outlet_ceiling < r) begin
                r = outlet_ceiling;
            end
            if (s_reg.phase == brl_pkg::PH_SLOW && slow_eff
                && !(acond_act && prio[brl_pkg::PRIO_SLOW]) && s_reg.ceil < r) begin
                r = s_reg.ceil;
            end
        end
        s_next.rate = r;

        // Pump inhibits and high-limit response
        s_next.hw_pump_off = hl_if.active
                          || (acond_act && src_is_hw
                              && s_reg.ctrl[brl_pkg::CTL_AC_PUMP_OFF]);
        s_next.sh_pump_off = acond_act && src_is_sh
                          && s_reg.ctrl[brl_pkg::CTL_AC_PUMP_OFF];
        s_next.lockout = hl_if.active && s_reg.ctrl[brl_pkg::CTL_HILIM_LOCK];
        s_next.hold    = hl_if.active && !s_reg.ctrl[brl_pkg::CTL_HILIM_LOCK];

        // Sticky events; a set in the same cycle beats the clear
        s_next.hilim_d = hl_if.active;
        s_next.acond_d = acond_act;
        ev[brl_pkg::EV_HILIM] = hl_if.active && !s_reg.hilim_d;
        ev[brl_pkg::EV_ACOND] = acond_act && !s_reg.acond_d;
        s_next.irq_st = (s_reg.irq_st & ~clr) | ev;
        s_next.irq    = |(s_next.irq_st & s_next.irq_en);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg        <= '0;
            s_reg.ctrl   <= brl_pkg::CTRL_RST;
            s_reg.sh_max <= brl_pkg::MAX_RST;
            s_reg.hw_max <= brl_pkg::MAX_RST;
            s_reg.ready  <= 1'b1;
            s_reg.phase  <= brl_pkg::PH_IDLE;
            s_reg.rate   <= brl_pkg::WORD_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign hreadyout              = s_reg.ready;
    assign hrdata                 = s_reg.rdata;
    assign hresp                  = s_reg.resp;
    assign rate_out               = s_reg.rate;
    assign hot_water_pump_off     = s_reg.hw_pump_off;
    assign space_heating_pump_off = s_reg.sh_pump_off;
    assign lockout_req            = s_reg.lockout;
    assign recycle_hold           = s_reg.hold;
    assign irq                    = s_reg.irq;
endmodule : brl_top

// [bench/brl_seq_model.sv]
// Purpose: Burner sequencer stand-in driving firing state and source
// Assumes: One lightoff pulse per firing cycle
// Notes:   Source held steady while firing, cleared when idle
module brl_seq_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       go,
    input  wire logic [1:0] src,
    output logic            firing,
    output logic            lightoff_done,
    output logic [1:0]      demand_src
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            firing <= 1'b0;
            lightoff_done <= 1'b0;
            demand_src <= 2'h0;
        end else begin
            firing <= go;
            // Stabilization ends with ignition here, no extra wait
            lightoff_done <= go & ~firing;
            demand_src <= go ? src : 2'h0;
        end
    end
endmodule : brl_seq_model

// [bench/brl_top_props.sv]
// Purpose: Port-level properties of the burner rate limiter
// Assumes: One clock, reset active high
// Notes:   Sees only brl_top ports
module brl_top_props #(parameter int unsigned SEC_CYCLES = 20) (
    input wire logic        sys_clk, rst, hsel, hwrite, hready, hreadyout, hresp, firing,
    input wire logic        lockout_req, recycle_hold, hot_water_pump_off,
    input wire logic        space_heating_pump_off,
    input wire logic [1:0]  htrans,
    input wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_req;
    assign rd_req = hsel & htrans[1] & hready & ~hwrite;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_rd_wait; rd_req |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_fast; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_wait_src; $fell(hreadyout) |-> $past(rd_req); endproperty
    a_wait_src: assert property (p_wait_src) else $error("stray wait");
    property p_rd_hold; $changed(hrdata) |-> $rose(hreadyout); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_one_resp; !(lockout_req && recycle_hold); endproperty
    a_one_resp: assert property (p_one_resp) else $error("two responses");
    property p_lim_pump; lockout_req || recycle_hold |-> hot_water_pump_off; endproperty
    a_lim_pump: assert property (p_lim_pump) else $error("pump on at limit");
    property p_ac_fire; !firing [*3] |-> !space_heating_pump_off; endproperty
    a_ac_fire: assert property (p_ac_fire) else $error("pump off unfired");
    c_read: cover property (rd_req);
    c_lock: cover property ($rose(lockout_req));
    c_hold: cover property ($rose(recycle_hold));
    c_ac: cover property ($rose(space_heating_pump_off));
endmodule : brl_top_props
bind brl_top brl_top_props #(.SEC_CYCLES(SEC_CYCLES)) u_props (.sys_clk, .rst, .hsel,
    .hwrite, .hready, .hreadyout, .hresp, .firing, .lockout_req, .recycle_hold,
    .hot_water_pump_off, .space_heating_pump_off, .htrans, .hrdata);

// [bench/brl_top_bench.sv]
// Purpose: Self-checking bench for the burner rate limiter
// Assumes: One second shortened to 20 cycles
// Notes:   Bus master tasks here, sequencer in its own model
module brl_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} brl_row_t;
    logic        sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
    logic        hreadyout, hresp, firing, lightoff_done, irq, lockout_req, recycle_hold;
    logic        hot_water_pump_off, space_heating_pump_off;
    logic [1:0]  htrans = 2'h0, src = 2'h0, demand_src;
    logic [15:0] outlet_temp = 16'h0040, hot_water_temp = 16'h0020, rate_out;
    logic [15:0] outlet_ceiling = 16'hFFFF, stack_ceiling = 16'hFFFF;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat;
    int          bad_count = 0, checks = 0;
    // Writable words read back; read-only and unmapped words must ignore writes
    brl_row_t    rows [4] = '{'{8'h04, 32'h3, 32'h3}, '{8'h2C, 32'h1F4, 32'h1F4},
                             '{8'h30, 32'hFF, 32'h0}, '{8'h4C, 32'hFFFF, 32'h0}};
    always #10 sys_clk = ~sys_clk;
    brl_top #(.SEC_CYCLES(20)) dut (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .firing,
        .lightoff_done, .demand_src, .outlet_temp, .hot_water_temp,
        .active_setpoint(16'h0080), .demand_rate(16'h0150), .stack_ceiling,
        .delta_t_ceiling(16'hFFFF), .outlet_ceiling, .rate_out, .hot_water_pump_off,
        .space_heating_pump_off, .lockout_req, .recycle_hold, .irq);
    brl_seq_model seq (.sys_clk, .rst, .go, .src, .firing, .lightoff_done, .demand_src);
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : wt
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(rdat, e);
    endtask : rd
    task automatic fire(input logic [1:0] s);
        go <= 1'b0;
        wt(3);
        src <= s;
        go <= 1'b1;
        wt(6);
    endtask : fire
    task automatic rt(input logic [15:0] e);
        chk(32'(rate_out), 32'(e));
    endtask : rt
    task automatic hw(input logic [15:0] t, input logic [31:0] e);
        hot_water_temp <= t;
        wt(4);
        chk(32'({lockout_req, recycle_hold, hot_water_pump_off}), e);
    endtask : hw
    task automatic ac(input logic [15:0] t, input logic [31:0] e);
        outlet_temp <= t;
        wt(4);
        chk(32'({space_heating_pump_off, rate_out}), e);
    endtask : ac
    task automatic conclude;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        wt(16);
        rst <= 1'b0;
        wt(1);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(1);
        rd(8'h04, 32'h0);
        rd(8'h2C, 32'hFFFF);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, 32'(1 << i));
            fire(i ? 2'h2 : 2'h1);
        end
        rd(8'h38, 32'h3);
        wr(8'h40, 32'h1);
        wt(2);
        chk(32'(irq), 32'h1);
        wr(8'h40, 32'h0);
        wt(2);
        chk(32'(irq), 32'h0);
        wr(8'h3C, 32'h3);
        rd(8'h38, 32'h0);
        wr(8'h08, 32'h64);
        wr(8'h28, 32'h1F4);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h0);
        fire(2'h1);
        rt(16'h0064);
        wt(50);
        rt(16'h0150);
        wr(8'h10, 32'h70);
        fire(2'h2);
        rt(16'h0150);
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h10);
        wr(8'h18, 32'h3C);
        wr(8'h00, 32'h1);
        fire(2'h1);
        rt(16'h0064);
        wt(205);
        rt(16'h006E);
        ac(16'h0070, 32'h0150);
        go <= 1'b0;
        wr(8'h1C, 32'h8C);
        for (int i = 0; i < 2; i++) begin
            wr(8'h00, 32'h4 | 32'(i << 3));
            hw(16'h008C, i ? 32'h5 : 32'h3);
            hw(16'h0087, i ? 32'h5 : 32'h3);
            hw(16'h0086, 32'h0);
        end
        wr(8'h20, 32'h60);
        wr(8'h00, 32'h1F50);
        outlet_ceiling <= 16'h0100;
        stack_ceiling <= 16'h0120;
        outlet_temp <= 16'h0040;
        fire(2'h1);
        ac(16'h0040, 32'h101F4);
        ac(16'h0063, 32'h101F4);
        ac(16'h0064, 32'h0100);
        wr(8'h00, 32'h1050);
        ac(16'h0040, 32'h10120);
        wr(8'h00, 32'h50);
        ac(16'h0040, 32'h10100);
        go <= 1'b0;
        wt(4);
        chk(32'(space_heating_pump_off), 32'h0);
        conclude();
    end
    initial begin
        wt(6000);
        bad_count++;
        conclude();
    end
endmodule : brl_top_bench
